/* File: common/hpp_pkg.sv */
package hpp_pkg;

	// =======================================================
	// pin bundle sampled from the host side
	typedef struct packed {
		logic       cs_n;
		logic       write_strobe_or_eclock;
		logic       rd_n_or_rw;
		logic       addr_strobe;
		logic [9:0] addr;
		logic [7:0] data;
		logic       data_fmt;
		logic       timing_fmt;
		logic       div_sel;
	} hpp_pins_t;

	// =======================================================
	// requests towards the internal ram and the core latches
	typedef struct packed {
		logic        re;
		logic        we;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} hpp_mem_req_t;

	typedef struct packed {
		logic       re;
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hpp_par_req_t;

	// =======================================================
	// pin encodings
	localparam logic FMT_STROBE_RW  = 1'b1;
	localparam logic TIMING_ASYNC   = 1'b1;
	localparam logic DIV_BY_TWO     = 1'b1;

	// window select on address bits 9..8
	localparam logic [1:0] WIN_PAGE0 = 2'h0;
	localparam logic [1:0] WIN_PAGE1 = 2'h1;
	localparam logic [1:0] WIN_BASE  = 2'h2;
	localparam logic [1:0] WIN_REGS  = 2'h3;

	// =======================================================
	// local parameter register offsets (low five bits)
	localparam logic [4:0] OFS_BASE_PTR = 5'h08;
	localparam logic [4:0] OFS_MODE2    = 5'h0c;
	localparam logic [4:0] OFS_EXT_CTRL = 5'h1c;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h1d;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h1e;
	localparam logic [4:0] OFS_TRIG_CMD = 5'h1f;

	// field positions
	localparam int MODE2_PORT0   = 0;
	localparam int MODE2_PORT1   = 1;
	localparam int CTRL_EXT_EN   = 0;
	localparam int IRQ_SYNC      = 0;
	localparam int IRQ_TRIG      = 1;
	localparam int TRIG_FIRE     = 0;

	// reset values
	localparam logic [7:0] RST_BASE_PTR = 8'h00;
	localparam logic [7:0] RST_MODE2    = 8'h00;
	localparam logic [7:0] RST_REG      = 8'h00;

	// segment shifts for the base pointer window
	localparam int SEG_SHIFT_COMPAT = 3;
	localparam int SEG_SHIFT_EXT    = 4;

endpackage

/* File: logic/hpp_host_port.sv */
// Overview of operation
// RL1: pins named with _n are active when low, on both sides.
// RL2: compatibility decode ignores address bits 7..5 for parameter registers.
// RL3: with extension decode enabled, all address bits decode parameter regs.
// RL4: four extension registers lie inside the aliased compatibility range.
// RL5: extended features off at reset, enabled only via formerly unused regs.
// RL6: extensions off gives the predecessor's register view unchanged.
// RL7: divided clock out is clock/4 when divider select 0, clock/2 when 1.
// RL8: synchronous strobe mode: one eclock pulse equals one memory cycle.
// RL9: asynchronous timing: device drives low-active ready to end each access.
// RL10: aux pin 1: mode2 bit 1 in compatibility, sync interrupt in extended.
// RL11: aux pin 0: mode2 bit 0 in compatibility, measurement trigger extended.
// RL12: address latch pin latches muxed address, or acts as address strobe.
// RL13: static data-format pin selects strobe meaning and byte format; here it selects the strobe meaning only.
// RL14: static timing pin selects synchronous or ready-handshaked timing.
// RL15: reset is driven by a host port pin; host decides release.
// RL16: address bits 9..8 select page 0, page 1, base window, registers.
// RL17: base pointer selects 8-byte segments, 16-byte in extended mode.
// RL18: data bus drivers off unless a selected read is in progress.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
module hpp_host_port
	import hpp_pkg::*;
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         reset,
	// host pins
	input  wire hpp_pins_t    pins,
	output logic [7:0]        data_out,
	output logic              data_oe,
	output logic              access_done_n,
	output logic              divided_clock_out,
	output logic              sync_irq_or_port1_n,
	output logic              trigger_or_port0_n,
	output logic              ext_irq_n,
	// core side
	output hpp_mem_req_t      mem_req,
	input  wire logic [7:0]   mem_rdata,
	output hpp_par_req_t      par_req,
	input  wire logic [7:0]   par_rdata,
	input  wire logic         sync_event,
	input  wire logic         trigger_event,
	output logic              ext_decode_enable
);

	// =======================================================
	// states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_REQ  = 4'b0010,
		ST_WAIT = 4'b0100,
		ST_HOLD = 4'b1000
	} hpp_state_t;

	// base window: segment start plus offset, wrapping inside the ram
	function automatic logic [11:0] base_addr(input logic [7:0] base,
		input logic [7:0] ofs, input logic ext);
		logic [12:0] seg;
		seg = ext ? ({5'h00, base} << SEG_SHIFT_EXT)
		          : ({5'h00, base} << SEG_SHIFT_COMPAT);
		base_addr = seg[11:0] + {4'h0, ofs};
	endfunction

	// =======================================================
	// decode helpers
	// local register hit: offset match inside the register window
	function automatic logic reg_hit(input logic in_win, input logic ok,
		input logic [4:0] got, input logic [4:0] want);
		reg_hit = in_win && ok && (got == want);
	endfunction

	// ram address for the three ram windows
	function automatic logic [11:0] window_addr(input logic [1:0] w,
		input logic [7:0] base, input logic [7:0] o, input logic ext);
		case (w)
			WIN_PAGE0: begin
				window_addr = {4'h0, o};
			end
			WIN_PAGE1: begin
				window_addr = {4'h1, o};
			end
			default: begin
				window_addr = base_addr(base, o, ext);
			end
		endcase
	endfunction

	// local register read value; only used when a local hit is taken
	// extension registers read as unused locations until enabled
	function automatic logic [7:0] local_read(input logic [4:0] o,
		input logic [7:0] base, input logic [7:0] m2, input logic ext,
		input logic [1:0] stat, input logic [1:0] mask);
		case (o)
			OFS_BASE_PTR: begin
				local_read = base;
			end
			OFS_MODE2: begin
				local_read = m2;
			end
			OFS_EXT_CTRL: begin
				local_read = {7'h00, ext};
			end
			OFS_IRQ_STAT: begin
				local_read = ext ? {6'h00, stat} : 8'h00;
			end
			OFS_IRQ_MASK: begin
				local_read = ext ? {6'h00, mask} : 8'h00;
			end
			default: begin
				local_read = 8'h00;
			end
		endcase
	endfunction

	// =======================================================
	// pin synchroniser: three stages, change taken when 2 and 3 agree
	hpp_pins_t  pin_s1;
	hpp_pins_t  pin_s2;
	hpp_pins_t  pin_s3;
	hpp_pins_t  st;

	// synced view resets inactive, so no false strobe follows reset
	always_ff @(posedge clk) begin
		pin_s1 <= pins;
		pin_s2 <= pin_s1;
		pin_s3 <= pin_s2;
		if (reset) begin
			st <= '1;
		end else begin
			st <= (pin_s2 & pin_s3) | (st & (pin_s2 ^ pin_s3));
		end
	end

	// =======================================================
	// registers and state
	hpp_state_t  state;
	hpp_state_t  next_state;
	logic [7:0]  base_ptr;
	logic [7:0]  mode2;
	logic        ext_en;
	logic [1:0]  irq_stat;
	logic [1:0]  irq_mask;
	logic        trig_q;
	logic [7:0]  ale_addr;
	logic        div_cnt;
	logic        is_rd;
	logic        is_local;
	logic        is_par;
	logic [7:0]  local_q;

	// =======================================================
	// strobe decode
	wire strobe_rw  = (st.data_fmt == FMT_STROBE_RW);            // [RL13]
	wire async_mode = (st.timing_fmt == TIMING_ASYNC);           // [RL14]
	wire muxed_bus_mode = !strobe_rw && !async_mode;
	// muxed bus: select from address pins 7..2 at zero, no chip select
	wire sel = muxed_bus_mode ? (st.addr[7:2] == 6'h00)
	                          : !st.cs_n;                        // [RL1]
	// strobe format: eclock high in sync, address strobe low in async
	wire rw_strobe = async_mode ? !st.addr_strobe
	                            : st.write_strobe_or_eclock;     // [RL8] [RL12]
	wire rd_act = sel && (strobe_rw ? (rw_strobe && st.rd_n_or_rw)
	                                : !st.rd_n_or_rw);           // [RL1]
	wire wr_act = sel && (strobe_rw ? (rw_strobe && !st.rd_n_or_rw)
	                                : !st.write_strobe_or_eclock);
	wire acc_act = rd_act || wr_act;

	// =======================================================
	// address decode
	wire [9:0] full_addr = muxed_bus_mode ? {st.addr[1:0], ale_addr}
	                                      : st.addr;
	wire [1:0] win  = full_addr[9:8];                            // [RL16]
	wire [7:0] ofs  = full_addr[7:0];
	wire       in_regs = (win == WIN_REGS);
	// compat decode drops bits 7..5, full decode demands them zero
	wire       hi_ok = !ext_en || (ofs[7:5] == 3'h0);            // [RL2] [RL3]
	wire [4:0] rofs = ofs[4:0];
	wire hit_base  = reg_hit(in_regs, hi_ok, rofs, OFS_BASE_PTR);
	wire hit_mode2 = reg_hit(in_regs, hi_ok, rofs, OFS_MODE2);
	wire hit_ctrl  = reg_hit(in_regs, hi_ok, rofs, OFS_EXT_CTRL); // [RL4]
	wire hit_stat  = reg_hit(in_regs, hi_ok, rofs, OFS_IRQ_STAT);
	wire hit_mask  = reg_hit(in_regs, hi_ok, rofs, OFS_IRQ_MASK);
	wire hit_trig  = reg_hit(in_regs, hi_ok, rofs, OFS_TRIG_CMD);
	wire hit_local = hit_base || hit_mode2 || hit_ctrl || hit_stat
	                 || hit_mask || hit_trig;
	// register index forwarded to the core latches, aliased only in compat decode
	wire [7:0] par_idx = ext_en ? ofs : {3'h0, rofs};            // [RL2] [RL3]
	wire [11:0] ram_addr = window_addr(win, base_ptr, ofs,
	                                   ext_en);              // [RL16] [RL17]

	wire [7:0] local_rd = local_read(rofs, base_ptr, mode2, ext_en,
	                                 irq_stat, irq_mask);        // [RL6]

	wire issue = (state == ST_IDLE) && acc_act;
	wire wr_go = issue && wr_act;
	wire rd_go = issue && rd_act;

	// =======================================================
	// access sequencer
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (acc_act) begin
					next_state = ST_REQ;
				end
			end
			ST_REQ: begin
				next_state = ST_WAIT;
			end
			ST_WAIT: begin
				next_state = ST_HOLD;
			end
			// one access per strobe: wait for release    [RL8]
			ST_HOLD: begin
				if (!acc_act) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state    <= ST_IDLE;
			is_rd    <= 1'b0;
			is_local <= 1'b0;
			is_par   <= 1'b0;
			local_q  <= RST_REG;
			data_out <= RST_REG;
		end else begin
			state <= next_state;
			if (issue) begin
				is_rd    <= rd_act;
				is_local <= hit_local;
				is_par   <= in_regs;
				local_q  <= local_rd;
			end
			if (state == ST_WAIT) begin
				data_out <= is_local ? local_q :
				            is_par ? par_rdata : mem_rdata;
			end
		end
	end

	// =======================================================
	// core requests, one-cycle pulses from flops
	always_ff @(posedge clk) begin
		if (reset) begin
			mem_req <= '0;
			par_req <= '0;
		end else begin
			mem_req.re    <= rd_go && !in_regs;
			mem_req.we    <= wr_go && !in_regs;
			mem_req.addr  <= ram_addr;
			mem_req.wdata <= st.data;
			par_req.re    <= rd_go && in_regs && !hit_local;
			par_req.we    <= wr_go && in_regs && !hit_local;
			par_req.addr  <= par_idx;
			par_req.wdata <= st.data;
		end
	end

	// =======================================================
	// local registers
	always_ff @(posedge clk) begin
		if (reset) begin
			base_ptr <= RST_BASE_PTR;
			mode2    <= RST_MODE2;
			ext_en   <= 1'b0;                                    // [RL5]
			irq_mask <= '0;
			ale_addr <= RST_REG;
		end else begin
			if (wr_go && hit_base) begin
				base_ptr <= st.data;
			end
			if (wr_go && hit_mode2) begin
				mode2 <= st.data;
			end
			// reachable before full decode is on                [RL4] [RL5]
			if (wr_go && hit_ctrl) begin
				ext_en <= st.data[CTRL_EXT_EN];
			end
			if (wr_go && hit_mask && ext_en) begin
				irq_mask <= st.data[1:0];
			end
			// address latch pin captures the muxed low byte       [RL12]
			if (muxed_bus_mode && st.addr_strobe) begin
				ale_addr <= st.data;
			end
		end
	end

	// =======================================================
	// events and interrupt: read clears, a new event wins
	wire sw_trig = wr_go && hit_trig && ext_en && st.data[TRIG_FIRE];
	wire [1:0] ev = ext_en ? {trigger_event || sw_trig, sync_event}
	                       : 2'h0;
	wire stat_rd = rd_go && hit_stat && ext_en;

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_stat <= '0;
			trig_q   <= 1'b0;
		end else begin
			irq_stat <= (stat_rd ? 2'h0 : irq_stat) | ev;
			trig_q   <= ev[IRQ_TRIG];
		end
	end

	// =======================================================
	// clock divider: the pin is a flop toggled on an enable pulse
	wire div_en = (st.div_sel == DIV_BY_TWO) || div_cnt;         // [RL7]

	always_ff @(posedge clk) begin
		if (reset) begin
			div_cnt           <= 1'b0;
			divided_clock_out <= 1'b0;
		end else begin
			div_cnt <= !div_cnt;
			if (div_en) begin
				divided_clock_out <= !divided_clock_out;        // [RL7]
			end
		end
	end

	// =======================================================
	// pins
	wire sync_pend = irq_stat[IRQ_SYNC] && irq_mask[IRQ_SYNC];

	wire any_pend  = |(irq_stat & irq_mask);
	wire in_hold   = (state == ST_HOLD);

	assign ext_decode_enable   = ext_en;
	assign ext_irq_n           = !any_pend;
	// compat mode shows the port bits, extended mode the events
	assign sync_irq_or_port1_n = ext_en ? !sync_pend
	                                    : mode2[MODE2_PORT1];    // [RL10]
	assign trigger_or_port0_n  = ext_en ? !trig_q
	                                    : mode2[MODE2_PORT0];    // [RL11]
	// sync timing gives no handshake; keep ready inactive
	assign access_done_n = !(async_mode && in_hold);             // [RL9]
	// drive only during a selected read once data is held
	assign data_oe = rd_act && is_rd && in_hold;                 // [RL18]

endmodule

/* File: test/hpp_chk_properties.sv */
module hpp_chk
	import hpp_pkg::*;
(
	// clock and reset
	input wire logic	clk,
	input wire logic	reset,
	// watched ports
	input wire hpp_pins_t	pins,
	input wire logic	data_oe,
	input wire logic	access_done_n,
	input wire logic	divided_clock_out,
	input wire logic	sync_irq_or_port1_n,
	input wire logic	trigger_or_port0_n,
	input wire logic	ext_irq_n,
	input wire hpp_mem_req_t	mem_req,
	input wire hpp_par_req_t	par_req,
	input wire logic	trigger_event,
	input wire logic	ext_decode_enable
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====
	// helpers
	logic [3:0]	div_age;
	logic [3:0]	rd_age;
	wire	req_any;
	wire	rd_now;
	assign req_any = mem_req.we | mem_req.re | par_req.we | par_req.re;
	assign rd_now = pins.data_fmt ? pins.rd_n_or_rw & (pins.timing_fmt ?
		!pins.addr_strobe : pins.write_strobe_or_eclock) : !pins.rd_n_or_rw;
	// pins are raw: allow for the synchroniser before judging
	always_ff @(posedge clk) begin
		div_age <= (reset | $changed(pins.div_sel)) ? 4'h0 :
			div_age + {3'h0, div_age != 4'hf};
		rd_age <= (reset | rd_now) ? 4'h0 : rd_age + {3'h0, rd_age != 4'hf};
	end
	// =====
	// properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence two_high_two_low;
		divided_clock_out ##1 !divided_clock_out ##1 !divided_clock_out;
	endsequence
	chk_div_four: assert property (
		div_age > 4'hb && !pins.div_sel && $rose(divided_clock_out)
		|=> two_high_two_low) else $error("clock out not clk/4");
	chk_div_two: assert property (
		div_age > 4'hb && pins.div_sel && $rose(divided_clock_out)
		|=> !divided_clock_out ##1 divided_clock_out)
		else $error("clock out not clk/2");
	chk_compat_alias: assert property (
		!ext_decode_enable && (par_req.we | par_req.re) |->
		par_req.addr[7:5] == 3'h0) else $error("alias bits decoded");
	chk_one_per_strobe: assert property (
		req_any |=> !req_any [*4]) else $error("two requests per strobe");
	chk_ready_async: assert property (
		!access_done_n |-> pins.timing_fmt == TIMING_ASYNC)
		else $error("ready driven in sync timing");
	chk_bus_release: assert property (
		data_oe |-> rd_age < 4'h8) else $error("data bus driven late");
	chk_write_quiet: assert property (
		mem_req.we | par_req.we |-> !data_oe) else $error("bus on in write");
	chk_sync_irq: assert property (
		ext_decode_enable && !sync_irq_or_port1_n |-> !ext_irq_n)
		else $error("sync interrupt without irq");
	chk_trig_pulse: assert property (
		ext_decode_enable && trigger_event |=> !trigger_or_port0_n)
		else $error("trigger pin missed event");
endmodule

bind hpp_host_port hpp_chk u_chk (.clk, .reset, .pins, .data_oe,
	.access_done_n, .divided_clock_out, .sync_irq_or_port1_n,
	.trigger_or_port0_n, .ext_irq_n, .mem_req, .par_req, .trigger_event,
	.ext_decode_enable);

/* File: test/hpp_host_model.sv */
module hpp_host_model
	import hpp_pkg::*;
(
	// clock
	input wire logic	clk,
	// device side of the bus
	input wire logic [7:0]	data_out,
	input wire logic	data_oe,
	input wire logic	access_done_n,
	output hpp_pins_t	pins
);
	timeunit 1ns;
	timeprecision 1ps;
	// =====
	// pin state, idle strobes high
	hpp_pins_t	p = '{cs_n: 1'b1, write_strobe_or_eclock: 1'b1,
		rd_n_or_rw: 1'b1, addr_strobe: 1'b1, timing_fmt: 1'b1, default: '0};
	logic [7:0]	drv = 8'h00;
	logic	ws_idle = 1'b1;
	logic	as_idle = 1'b1;
	// released bus shows no stale copy of the last value
	always_comb begin
		pins = p;
		pins.data = data_oe ? data_out : drv;
	end
	// =====
	// static pins; e idles low and as ties high in sync r/w
	task automatic cfg(input logic [1:0] fmt, input logic div);
		@(posedge clk);
		ws_idle = fmt != 2'b10;
		as_idle = fmt != 2'b00;
		{p.data_fmt, p.timing_fmt} <= fmt;
		p.div_sel <= div;
		p.write_strobe_or_eclock <= ws_idle;
		p.addr_strobe <= as_idle;
		repeat (6) @(posedge clk);
	endtask
	// =====
	// one access per strobe or e pulse
	task automatic access(input logic rd, input logic [9:0] a,
			input logic [7:0] wd, output logic [7:0] q);
		@(posedge clk);
		if (!p.data_fmt && !p.timing_fmt) begin
			p.addr <= {8'h00, a[9:8]};
			drv <= a[7:0];
			p.addr_strobe <= 1'b1;
			repeat (5) @(posedge clk);
			p.addr_strobe <= 1'b0;
		end else
			p.addr <= a;
		p.cs_n <= 1'b0;
		drv <= rd ? ~drv : wd;
		if (p.data_fmt) begin
			p.rd_n_or_rw <= rd;
			if (p.timing_fmt)
				p.addr_strobe <= 1'b0;
			else
				p.write_strobe_or_eclock <= 1'b1;
		end else if (rd)
			p.rd_n_or_rw <= 1'b0;
		else
			p.write_strobe_or_eclock <= 1'b0;
		for (int n = 0; n < 12; n++) begin
			@(negedge clk);
			if (p.timing_fmt ? !access_done_n : n == 11)
				break;
		end
		q = pins.data;
		@(posedge clk);
		p.cs_n <= 1'b1;
		p.rd_n_or_rw <= 1'b1;
		p.write_strobe_or_eclock <= ws_idle;
		p.addr_strobe <= as_idle;
		drv <= ~drv;
		repeat (8) @(posedge clk);
	endtask
endmodule

/* File: test/tb.sv */
module tb
	import hpp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {logic [1:0] f; logic r; logic [9:0] a; logic [7:0] d;
		logic [1:0] k; logic [11:0] ea; logic [7:0] ed;} hpp_row_t;
	logic	clk = 1'b0;
	logic	reset = 1'b1;
	logic	sync_event = 1'b0;
	logic	trigger_event = 1'b0;
	logic [7:0]	mem_rdata = 8'h00, par_rdata = 8'h00, data_out, rdv;
	logic	data_oe, access_done_n, divided_clock_out, ext_irq_n;
	logic	sync_irq_or_port1_n, trigger_or_port0_n, ext_decode_enable;
	hpp_pins_t	pins;
	hpp_mem_req_t	mem_req, last_mem;
	hpp_par_req_t	par_req, last_par;
	int	errors = 0, compares = 0, n_we = 0, rises;
	logic	prev;
	hpp_row_t	rows[9] = '{
		'{2'b01, 0, 10'h005, 8'h11, 1, 12'h005, 8'h11},
		'{2'b01, 1, 10'h105, 8'h00, 1, 12'h105, 8'ha0},
		'{2'b01, 0, 10'h3e3, 8'h22, 2, 12'h003, 8'h22},
		'{2'b01, 1, 10'h3a7, 8'h00, 2, 12'h007, 8'h3b},
		'{2'b01, 0, 10'h308, 8'h12, 0, 12'h000, 8'h00},
		'{2'b01, 1, 10'h203, 8'h00, 1, 12'h093, 8'h36},
		'{2'b10, 0, 10'h0ff, 8'h33, 1, 12'h0ff, 8'h33},
		'{2'b10, 1, 10'h1f0, 8'h00, 1, 12'h1f0, 8'h55},
		'{2'b00, 0, 10'h144, 8'h99, 1, 12'h144, 8'h99}};

	always #2.5 clk = ~clk;
	hpp_host_port dut (.clk, .reset, .pins, .data_out, .data_oe,
		.access_done_n, .divided_clock_out, .sync_irq_or_port1_n,
		.trigger_or_port0_n, .ext_irq_n, .mem_req, .mem_rdata, .par_req,
		.par_rdata, .sync_event, .trigger_event, .ext_decode_enable);
	hpp_host_model host (.clk, .data_out, .data_oe, .access_done_n, .pins);

	// =====
	// core side: data one cycle after re, junk otherwise
	always @(posedge clk) begin
		mem_rdata <= mem_req.re ? mem_req.addr[7:0] ^ 8'ha5 : ~mem_rdata;
		par_rdata <= par_req.re ? par_req.addr ^ 8'h3c : ~par_rdata;
		if (mem_req.we | mem_req.re)
			last_mem <= mem_req;
		if (par_req.we | par_req.re)
			last_par <= par_req;
		n_we <= n_we + int'(mem_req.we);
	end

	task automatic check(input string what, input logic [11:0] e,
			input logic [11:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic conclude();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic pulse(input logic s);
		@(posedge clk);
		sync_event <= s;
		trigger_event <= !s;
		@(posedge clk);
		sync_event <= 1'b0;
		trigger_event <= 1'b0;
		repeat (3) @(negedge clk);
	endtask

	// about 550 cycles of tests; far more means a hang
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		conclude();
	end

	initial begin
		repeat (5) @(negedge clk);
		check("reset", 12'h14, {access_done_n, data_oe, ext_irq_n,
			ext_decode_enable, divided_clock_out});
		@(posedge clk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			host.cfg(rows[i].f, 1'b0);
			host.access(rows[i].r, rows[i].a, rows[i].d, rdv);
			if (rows[i].k != 0) begin
				check("addr", rows[i].ea, rows[i].k == 2 ?
					{4'h0, last_par.addr} : last_mem.addr);
				check("data", {4'h0, rows[i].ed}, {4'h0, rows[i].r ? rdv :
					rows[i].k == 2 ? last_par.wdata : last_mem.wdata});
			end
			$display("row %0d done", i);
		end
		check("writes", 12'h3, 12'(n_we));
		host.cfg(2'b01, 1'b0);
		host.access(0, 10'h31e, 8'hff, rdv);
		host.access(1, 10'h31e, 8'h00, rdv);
		check("ext reg off", 12'h0, {4'h0, rdv});
		host.access(0, 10'h30c, 8'h02, rdv);
		check("ports", 12'h2, {sync_irq_or_port1_n, trigger_or_port0_n});
		host.access(0, 10'h3fc, 8'h01, rdv);
		check("ext on", 12'h1, {11'h0, ext_decode_enable});
		host.access(0, 10'h3e3, 8'h44, rdv);
		check("full decode", 12'h0e3, {4'h0, last_par.addr});
		host.access(1, 10'h203, 8'h00, rdv);
		check("segment", 12'h123, last_mem.addr);
		$display("decode tests done");
		host.access(0, 10'h31e, 8'h01, rdv);
		pulse(1'b0);
		check("masked", 12'h1, {11'h0, ext_irq_n});
		pulse(1'b1);
		check("irq", 12'h0, {ext_irq_n, sync_irq_or_port1_n});
		host.access(1, 10'h31d, 8'h00, rdv);
		check("status", 12'h3, {4'h0, rdv});
		check("cleared", 12'h1, {11'h0, ext_irq_n});
		host.access(0, 10'h31f, 8'h01, rdv);
		host.access(1, 10'h31d, 8'h00, rdv);
		check("sw trigger", 12'h2, {4'h0, rdv});
		$display("interrupt test done");
		for (int k = 0; k < 2; k++) begin
			host.cfg(2'b01, k[0]);
			repeat (8) @(negedge clk);
			rises = 0;
			prev = divided_clock_out;
			repeat (40) begin
				@(negedge clk);
				rises += int'(divided_clock_out && !prev);
				prev = divided_clock_out;
			end
			check("rises", k ? 12'd20 : 12'd10, 12'(rises));
		end
		$display("divider test done");
		@(posedge clk);
		reset <= 1'b1;
		repeat (5) @(negedge clk);
		check("second reset", 12'h0, {11'h0, ext_decode_enable});
		@(posedge clk);
		reset <= 1'b0;
		$display("reset test done");
		conclude();
	end
endmodule
